// *** design/ibsu_defs.svh ***
`ifndef IBSU_DEFS_SVH
`define IBSU_DEFS_SVH

// ************************************************************
// timing
// ************************************************************
`define IBSU_CLK_NS 4
`define IBSU_T1_NS 2000
`define IBSU_T1_CYC ((`IBSU_T1_NS + `IBSU_CLK_NS - 1) / `IBSU_CLK_NS)

// ************************************************************
// addressing and command codes
// ************************************************************
`define IBSU_ADDR_OFF 5'h1f
`define IBSU_GRP_LISTEN 2'h1
`define IBSU_GRP_TALK 2'h2
`define IBSU_GRP_SECOND 2'h3
`define IBSU_CMD_UNL 7'h3f
`define IBSU_CMD_UNT 7'h5f
`define IBSU_CMD_DCL 7'h14
`define IBSU_CMD_SDC 7'h04
`define IBSU_CMD_SPE 7'h18
`define IBSU_CMD_SPD 7'h19

// ************************************************************
// characters and status values
// ************************************************************
`define IBSU_CHR_LF 8'h0a
`define IBSU_CHR_CR 8'h0d
`define IBSU_STB_PWR_OK 8'h41
`define IBSU_STB_RQS 2'h1

// ************************************************************
// transmit buffer
// ************************************************************
`define IBSU_FIFO_DEPTH 32
`define IBSU_FIFO_WIDTH 9

`endif

// *** design/ibsu_fifo.sv ***
`timescale 1ns/10ps

module ibsu_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic [AW:0] cnt;
        logic in_ready;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } ibsu_fq_s;

    logic [WIDTH-1:0] mem [DEPTH];
    ibsu_fq_s q_reg;
    ibsu_fq_s q_next;
    logic push;
    logic pop;

    assign push = in_valid && q_reg.in_ready;
    // read only from filled slots, so a write never races its own read
    assign pop = (q_reg.cnt != '0) && (!q_reg.out_valid || out_ready);

    always_comb begin
        q_next = q_reg;
        if (push) begin
            q_next.wp = q_reg.wp + 1'b1;
        end
        if (pop) begin
            q_next.rp = q_reg.rp + 1'b1;
            q_next.out_valid = 1'b1;
            q_next.out_data = mem[q_reg.rp[AW-1:0]];
        end else if (out_ready) begin
            q_next.out_valid = 1'b0;
        end
        q_next.cnt = q_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush) begin
            q_next = '0;
        end
        // registered ready; the output register holds one of the DEPTH words
        q_next.in_ready = ((q_next.cnt + (AW + 1)'(q_next.out_valid)) != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[q_reg.wp[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign in_ready = q_reg.in_ready;
    assign out_valid = q_reg.out_valid;
    assign out_data = q_reg.out_data;

endmodule

// *** design/ibsu_pkg.sv ***
package ibsu_pkg;

    typedef enum logic [1:0] {
        P_CAPT = 2'b00,
        P_TEST = 2'b01,
        P_RUN = 2'b10
    } ibsu_pwr_e;

    typedef enum logic [0:0] {
        AH_IDLE = 1'b0,
        AH_HOLD = 1'b1
    } ibsu_ah_e;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_SETTLE = 2'b01,
        SH_WAIT = 2'b10,
        SH_DAV = 2'b11
    } ibsu_sh_e;

    // lines read as true while asserted on the bus
    typedef struct packed {
        logic [7:0] dio;
        logic atn;
        logic eoi;
        logic dav;
        logic nrfd;
        logic ndac;
        logic ifc;
    } ibsu_bus_in_s;

    // each *_oe high pulls that line to its asserted level; dio_oe drives the dio byte instead
    typedef struct packed {
        logic [7:0] dio;
        logic dio_oe;
        logic eoi_oe;
        logic dav_oe;
        logic nrfd_oe;
        logic ndac_oe;
        logic srq_oe;
    } ibsu_bus_out_s;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } ibsu_word_s;

    typedef struct packed {
        ibsu_pwr_e pwr;
        ibsu_ah_e ah;
        ibsu_sh_e sh;
        logic [4:0] addr;
        logic term_lf;
        logic lstn;
        logic talk;
        logic spe;
        logic pwr_pend;
        logic ev_pend;
        logic [5:0] ev_code;
        logic [7:0] status;
        logic [8:0] cnt;
        logic [1:0] phase;
        logic [7:0] tx_byte;
        logic tx_eoi;
        logic sp_tx;
        logic held;
        ibsu_bus_out_s bus;
        logic rx_valid;
        ibsu_word_s rx_word;
        logic dev_clear;
        logic st_start;
        logic init_req;
    } ibsu_state_s;

endpackage

// *** design/ibsu_top.sv ***
`timescale 1ns/10ps
`include "ibsu_defs.svh"

module ibsu_top
    import ibsu_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // rear switches
    input wire logic [4:0] addr_sw,
    input wire logic term_lf_sw,
    // self-test and initialisation
    output logic st_start,
    input wire logic st_done,
    input wire logic st_fail,
    input wire logic [7:0] st_code,
    output logic init_req,
    // bus
    input wire ibsu_pkg::ibsu_bus_in_s bus_i,
    output ibsu_pkg::ibsu_bus_out_s bus_o,
    // outgoing message stream
    input wire logic tx_valid,
    input wire ibsu_pkg::ibsu_word_s tx_word,
    output logic tx_ready,
    // incoming message stream
    output logic rx_valid,
    output ibsu_pkg::ibsu_word_s rx_word,
    // status events and clear
    input wire logic ev_set,
    input wire logic [5:0] ev_code,
    output logic dev_clear,
    output logic listen,
    output logic talk
);
    import ibsu_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rs_reg;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rs_reg <= 2'b00;
        end else begin
            rs_reg <= {rs_reg[0], 1'b1};
        end
    end
    assign rst_n = rs_reg[1];

    // ************************************************************
    // transmit buffer
    // ************************************************************
    ibsu_state_s r_reg;
    ibsu_state_s r_next;
    ibsu_word_s fq_word;
    logic fq_valid;
    logic fq_pop;
    logic fq_flush;

    ibsu_fifo #(
        .WIDTH(`IBSU_FIFO_WIDTH),
        .DEPTH(`IBSU_FIFO_DEPTH)
    ) u_txq (
        .clk(ref_clk),
        .rst_n(rst_n),
        .flush(fq_flush),
        .in_valid(tx_valid),
        .in_data(tx_word),
        .in_ready(tx_ready),
        .out_valid(fq_valid),
        .out_data(fq_word),
        .out_ready(fq_pop)
    );

    // ************************************************************
    // decode helpers
    // ************************************************************
    logic run;
    logic acc_act;
    logic talk_act;
    logic ours;
    logic [6:0] cmd;
    logic clr;

    assign run = (r_reg.pwr == P_RUN);
    assign acc_act = run && (bus_i.atn || r_reg.lstn);
    assign talk_act = run && r_reg.talk && !bus_i.atn;
    assign ours = (r_reg.addr != `IBSU_ADDR_OFF);
    assign cmd = bus_i.dio[6:0];
    assign clr = (cmd == `IBSU_CMD_DCL) || ((cmd == `IBSU_CMD_SDC) && r_reg.lstn);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        r_next = r_reg;
        r_next.rx_valid = 1'b0;
        r_next.dev_clear = 1'b0;
        r_next.st_start = 1'b0;
        r_next.init_req = 1'b0;
        fq_pop = 1'b0;
        fq_flush = 1'b0;

        case (r_reg.pwr)
            P_CAPT: begin
                r_next.addr = addr_sw;
                r_next.term_lf = term_lf_sw;
                r_next.st_start = 1'b1;
                r_next.pwr = P_TEST;
            end
            P_TEST: begin
                if (st_done) begin
                    r_next.status = st_fail ? st_code : `IBSU_STB_PWR_OK;
                    r_next.pwr_pend = 1'b1;
                    r_next.init_req = 1'b1;
                    r_next.pwr = P_RUN;
                end
            end
            P_RUN: begin
            end
            default: begin
                r_next.pwr = P_CAPT;
            end
        endcase

        // acceptor handshake
        case (r_reg.ah)
            AH_IDLE: begin
                r_next.bus.ndac_oe = acc_act;
                r_next.bus.nrfd_oe = 1'b0;
                if (acc_act && bus_i.dav) begin
                    r_next.bus.nrfd_oe = 1'b1;
                    r_next.bus.ndac_oe = 1'b0;
                    r_next.ah = AH_HOLD;
                    if (bus_i.atn) begin
                        if (cmd[6:5] == `IBSU_GRP_LISTEN) begin
                            if (cmd == `IBSU_CMD_UNL) begin
                                r_next.lstn = 1'b0;
                            end else if (ours && cmd[4:0] == r_reg.addr) begin
                                r_next.lstn = 1'b1;
                                r_next.talk = 1'b0;
                            end
                        end else if (cmd[6:5] == `IBSU_GRP_TALK) begin
                            if (ours && cmd[4:0] == r_reg.addr) begin
                                r_next.talk = 1'b1;
                                r_next.lstn = 1'b0;
                            end else begin
                                r_next.talk = 1'b0;
                            end
                        end else if (cmd[6:5] == `IBSU_GRP_SECOND) begin
                            r_next.lstn = r_reg.lstn;
                        end else if (cmd == `IBSU_CMD_SPE) begin
                            r_next.spe = 1'b1;
                        end else if (cmd == `IBSU_CMD_SPD) begin
                            r_next.spe = 1'b0;
                        end else if (clr) begin
                            r_next.dev_clear = 1'b1;
                            r_next.ev_pend = 1'b0;
                            r_next.phase = 2'd0;
                            r_next.held = 1'b0;
                            fq_flush = 1'b1;
                        end
                    end else begin
                        r_next.rx_valid = 1'b1;
                        r_next.rx_word.data = bus_i.dio;
                        r_next.rx_word.last = bus_i.eoi
                            || (r_reg.term_lf && bus_i.dio == `IBSU_CHR_LF);
                    end
                end
            end
            AH_HOLD: begin
                if (!bus_i.dav) begin
                    r_next.bus.nrfd_oe = 1'b0;
                    r_next.bus.ndac_oe = acc_act;
                    r_next.ah = AH_IDLE;
                end
            end
            default: begin
                r_next.ah = AH_IDLE;
            end
        endcase

        // source handshake; atn or loss of talk parks a data byte, a status byte is not parked
        if (r_reg.sh != SH_IDLE && !talk_act) begin
            r_next.sh = SH_IDLE;
            r_next.held = !r_reg.sp_tx;
            r_next.bus.dav_oe = 1'b0;
            r_next.bus.dio_oe = 1'b0;
            r_next.bus.eoi_oe = 1'b0;
        end else begin
            case (r_reg.sh)
                SH_IDLE: begin
                    r_next.cnt = '0;
                    r_next.sp_tx = 1'b0;
                    if (talk_act) begin
                        r_next.sh = SH_SETTLE;
                        if (r_reg.spe) begin
                            r_next.sp_tx = 1'b1;
                            r_next.tx_eoi = 1'b0;
                            r_next.tx_byte = r_reg.pwr_pend ? r_reg.status
                                : {`IBSU_STB_RQS, r_reg.ev_code};
                        end else if (r_reg.held) begin
                            r_next.held = 1'b0;
                        end else if (r_reg.phase == 2'd1) begin
                            r_next.tx_byte = `IBSU_CHR_CR;
                            r_next.tx_eoi = 1'b0;
                            r_next.phase = 2'd2;
                        end else if (r_reg.phase == 2'd2) begin
                            r_next.tx_byte = `IBSU_CHR_LF;
                            r_next.tx_eoi = 1'b1;
                            r_next.phase = 2'd0;
                        end else if (fq_valid) begin
                            fq_pop = 1'b1;
                            r_next.tx_byte = fq_word.data;
                            r_next.tx_eoi = fq_word.last && !r_reg.term_lf;
                            r_next.phase = (fq_word.last && r_reg.term_lf) ? 2'd1 : 2'd0;
                        end else begin
                            r_next.sh = SH_IDLE;
                        end
                    end
                end
                SH_SETTLE: begin
                    r_next.bus.dio = r_reg.tx_byte;
                    r_next.bus.dio_oe = 1'b1;
                    r_next.bus.eoi_oe = r_reg.tx_eoi;
                    // data settle before dav
                    r_next.cnt = r_reg.cnt + 9'd1;
                    if (r_reg.cnt == 9'(`IBSU_T1_CYC - 1)) begin
                        r_next.sh = SH_WAIT;
                    end
                end
                SH_WAIT: begin
                    if (!bus_i.nrfd) begin
                        r_next.bus.dav_oe = 1'b1;
                        r_next.sh = SH_DAV;
                    end
                end
                SH_DAV: begin
                    if (!bus_i.ndac) begin
                        r_next.bus.dav_oe = 1'b0;
                        r_next.bus.dio_oe = 1'b0;
                        r_next.bus.eoi_oe = 1'b0;
                        r_next.sh = SH_IDLE;
                        if (r_reg.sp_tx) begin
                            if (r_reg.pwr_pend) begin
                                r_next.pwr_pend = 1'b0;
                            end else begin
                                r_next.ev_pend = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    r_next.sh = SH_IDLE;
                end
            endcase
        end

        // interface clear: idle talk and listen, drop output buffer
        if (bus_i.ifc) begin
            r_next.talk = 1'b0;
            r_next.lstn = 1'b0;
            r_next.spe = 1'b0;
            r_next.phase = 2'd0;
            r_next.held = 1'b0;
            fq_flush = 1'b1;
        end

        // new event beats a clear in the same cycle
        if (ev_set) begin
            r_next.ev_pend = 1'b1;
            r_next.ev_code = ev_code;
        end

        r_next.bus.srq_oe = r_next.pwr_pend || r_next.ev_pend;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign bus_o = r_reg.bus;
    assign st_start = r_reg.st_start;
    assign init_req = r_reg.init_req;
    assign rx_valid = r_reg.rx_valid;
    assign rx_word = r_reg.rx_word;
    assign dev_clear = r_reg.dev_clear;
    assign listen = r_reg.lstn;
    assign talk = r_reg.talk;

endmodule

// *** verif/ibsu_ctrl_model.sv ***
`timescale 1ns/10ps
// ****
// controller model: source and acceptor
// ****
module ibsu_ctrl_model (
    // clock
    input wire logic ref_clk,
    // bus
    output ibsu_pkg::ibsu_bus_in_s bus_i,
    input wire ibsu_pkg::ibsu_bus_out_s bus_o
);
    import ibsu_pkg::*;
    logic [7:0] c_dio = 8'h00;
    logic c_atn = 1'b0;
    logic c_eoi = 1'b0;
    logic c_dav = 1'b0;
    logic c_nrfd = 1'b1;
    logic c_ndac = 1'b1;
    // released lines fall back to false through the pull-ups
    assign bus_i = '{dio: c_dio | (bus_o.dio_oe ? bus_o.dio : 8'h00), atn: c_atn,
        eoi: c_eoi | bus_o.eoi_oe, dav: c_dav | bus_o.dav_oe,
        nrfd: c_nrfd | bus_o.nrfd_oe, ndac: c_ndac | bus_o.ndac_oe, ifc: 1'b0};
    task automatic send(input logic atn, input logic [7:0] d, input logic eoi);
        int n;
        @(negedge ref_clk);
        c_atn = atn;
        c_dio = d;
        c_eoi = eoi;
        c_nrfd = 1'b0;
        c_ndac = 1'b0;
        repeat (2) @(negedge ref_clk);
        c_dav = 1'b1;
        n = 0;
        // a refused byte just times out here
        do begin @(negedge ref_clk); n++; end while (!bus_i.nrfd && n < 8);
        c_dav = 1'b0;
        n = 0;
        do begin @(negedge ref_clk); n++; end while (!bus_i.ndac && n < 8);
        c_dio = 8'h00;
        c_eoi = 1'b0;
        c_nrfd = 1'b1;
        c_ndac = 1'b1;
    endtask
    task automatic recv(input int stall, output logic [7:0] d, output logic e);
        int n;
        @(negedge ref_clk);
        c_atn = 1'b0;
        repeat (stall) @(negedge ref_clk);
        c_nrfd = 1'b0;
        n = 0;
        while (!bus_i.dav && n < 1200) begin @(negedge ref_clk); n++; end
        d = bus_i.dio;
        e = bus_i.eoi;
        c_nrfd = 1'b1;
        repeat (stall) @(negedge ref_clk);
        c_ndac = 1'b0;
        n = 0;
        while (bus_i.dav && n < 8) begin @(negedge ref_clk); n++; end
        c_ndac = 1'b1;
    endtask
endmodule

// *** verif/ibsu_top_sva.sv ***
`timescale 1ns/10ps
`include "ibsu_defs.svh"
// ****
// port checker
// ****
module ibsu_top_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // switches and self-test
    input wire logic [4:0] addr_sw,
    input wire logic term_lf_sw,
    input wire logic st_start,
    input wire logic st_done,
    input wire logic st_fail,
    input wire logic [7:0] st_code,
    input wire logic init_req,
    // bus
    input wire ibsu_pkg::ibsu_bus_in_s bus_i,
    input wire ibsu_pkg::ibsu_bus_out_s bus_o,
    // streams and events
    input wire logic tx_valid,
    input wire ibsu_pkg::ibsu_word_s tx_word,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire ibsu_pkg::ibsu_word_s rx_word,
    input wire logic ev_set,
    input wire logic [5:0] ev_code,
    input wire logic dev_clear,
    input wire logic listen,
    input wire logic talk
);
    import ibsu_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic done_seen;
    logic [2:0] since_rel;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_seen <= 1'b0;
            since_rel <= 3'h7;
        end else begin
            done_seen <= done_seen | st_done;
            since_rel <= ($fell(bus_o.dav_oe) || dev_clear) ? 3'h0 :
                since_rel + {2'b00, since_rel != 3'h7};
        end
    end
    a_no_addr_off: assert property (
        addr_sw == `IBSU_ADDR_OFF |-> !listen && !talk)
        else $error("addressed while switches select 31");
    a_rx_last_flag: assert property (
        rx_valid |-> rx_word.last == ($past(bus_i.eoi) ||
        (term_lf_sw && rx_word.data == `IBSU_CHR_LF)))
        else $error("received end flag wrong");
    a_eoi_only_lf: assert property (
        term_lf_sw && bus_o.eoi_oe |-> bus_o.dio_oe && bus_o.dio == `IBSU_CHR_LF)
        else $error("eoi away from line feed");
    a_second_ignored: assert property (
        $rose(bus_i.dav) && bus_i.atn && bus_i.dio[6:5] == `IBSU_GRP_SECOND
        |=> ($stable(listen) && $stable(talk)) [*2])
        else $error("secondary address changed state");
    a_dcl_clear_pulse: assert property (
        $rose(bus_i.dav) && bus_i.atn && bus_i.dio[6:0] == `IBSU_CMD_DCL
        |-> ##[1:2] dev_clear)
        else $error("device clear not signalled");
    a_srq_release_cause: assert property (
        $fell(bus_o.srq_oe) |-> since_rel <= 3'h3 || dev_clear || $fell(bus_o.dav_oe))
        else $error("service request dropped without poll or clear");
    a_srq_after_init: assert property (
        init_req |=> bus_o.srq_oe)
        else $error("no service request after power-up");
    a_init_after_test: assert property (
        init_req |-> done_seen)
        else $error("initialise before self-test done");
    c_poll_done: cover property ($fell(bus_o.srq_oe));
    c_fifo_full: cover property ($fell(tx_ready));
    c_lf_end: cover property (bus_o.eoi_oe && term_lf_sw);
    c_rx_end: cover property (rx_valid && rx_word.last);
endmodule

// *** verif/tb_ibsu_top.sv ***
`timescale 1ns/10ps
`include "ibsu_defs.svh"
// ****
// bench top
// ****
module tb_ibsu_top;
    import ibsu_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b1;
    logic [4:0] addr_sw = 5'h00;
    logic term_lf_sw = 1'b0;
    logic st_done = 1'b0;
    logic st_fail = 1'b0;
    logic [7:0] st_code = 8'h00;
    logic tx_valid = 1'b0;
    ibsu_word_s tx_word = '0;
    logic ev_set = 1'b0;
    logic [5:0] ev_code = 6'h00;
    logic st_start, init_req, tx_ready, rx_valid, dev_clear, listen, talk;
    ibsu_bus_in_s bus_i;
    ibsu_bus_out_s bus_o;
    ibsu_word_s rx_word;
    int mismatches = 0;
    int n_compared = 0;
    int n_init = 0;
    int n_clr = 0;
    int k;
    logic [8:0] rx_q[$];
    logic [8:0] exp_q[$];
    logic [7:0] d;
    logic e;
    logic [7:0] code;

    always #2 ref_clk = ~ref_clk;

    ibsu_top u_ibsu_top (.ref_clk(ref_clk), .reset_n(reset_n), .addr_sw(addr_sw),
        .term_lf_sw(term_lf_sw), .st_start(st_start), .st_done(st_done), .st_fail(st_fail),
        .st_code(st_code), .init_req(init_req), .bus_i(bus_i), .bus_o(bus_o),
        .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_word(rx_word), .ev_set(ev_set), .ev_code(ev_code), .dev_clear(dev_clear),
        .listen(listen), .talk(talk));
    ibsu_ctrl_model u_ibsu_ctrl_model (.ref_clk(ref_clk), .bus_i(bus_i), .bus_o(bus_o));

    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) rx_q.push_back({rx_word.last, rx_word.data});
        if (init_req === 1'b1) n_init++;
        if (dev_clear === 1'b1) n_clr++;
    end

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic power_up(input logic [4:0] a, input logic lf, input logic fl,
        input logic [7:0] c);
        int n;
        @(negedge ref_clk);
        reset_n = 1'b0;
        addr_sw = a;
        term_lf_sw = lf;
        st_fail = fl;
        st_code = c;
        n_init = 0;
        rx_q.delete();
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        n = 0;
        while (st_start !== 1'b1 && n < 20) begin @(negedge ref_clk); n++; end
        chk("st_start", 9'h001, {8'h00, st_start});
        repeat (3) @(negedge ref_clk);
        st_done = 1'b1;
        @(negedge ref_clk);
        st_done = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("init_req", 9'h001, 9'(n_init));
        chk("srq", 9'h001, {8'h00, bus_o.srq_oe});
    endtask

    task automatic poll(input logic [7:0] stb);
        u_ibsu_ctrl_model.send(1'b1, 8'h18, 1'b0);
        u_ibsu_ctrl_model.send(1'b1, 8'h40 | {3'b000, addr_sw}, 1'b0);
        u_ibsu_ctrl_model.recv($urandom % 40, d, e);
        chk("status byte", {1'b0, stb}, {1'b0, d});
        repeat (4) @(negedge ref_clk);
        chk("srq after poll", 9'h000, {8'h00, bus_o.srq_oe});
        u_ibsu_ctrl_model.send(1'b1, 8'h19, 1'b0);
        u_ibsu_ctrl_model.send(1'b1, 8'h5f, 1'b0);
    endtask

    task automatic listen_msg();
        logic [7:0] b [3];
        int c0;
        b[0] = 8'h41 + 8'($urandom % 26);
        b[1] = `IBSU_CHR_LF;
        b[2] = 8'h41 + 8'($urandom % 26);
        u_ibsu_ctrl_model.send(1'b1, 8'h20 | {3'b000, addr_sw}, 1'b0);
        u_ibsu_ctrl_model.send(1'b1, 8'h60 | 8'($urandom % 32), 1'b0);
        chk("listen", 9'h001, {8'h00, listen});
        c0 = n_clr;
        u_ibsu_ctrl_model.send(1'b1, 8'h04, 1'b0);
        chk("sdc", 9'(c0 + 1), 9'(n_clr));
        for (int i = 0; i < 3; i++) u_ibsu_ctrl_model.send(1'b0, b[i], i == 2);
        u_ibsu_ctrl_model.send(1'b1, 8'h3f, 1'b0);
        chk("rx count", 9'h003, 9'(rx_q.size()));
        for (int i = 0; i < 3; i++) begin
            chk("rx word", {(i == 2) || (term_lf_sw && i == 1), b[i]}, rx_q.pop_front());
        end
    endtask

    // refusal shows as tx_ready low before the edge
    task automatic fill(input int n, input int last_i, output int cnt);
        cnt = 0;
        while (cnt < n) begin
            @(negedge ref_clk);
            if (tx_ready !== 1'b1) break;
            tx_word = '{data: 8'($urandom), last: cnt == last_i};
            tx_valid = 1'b1;
            exp_q.push_back({!term_lf_sw && cnt == last_i, tx_word.data});
            cnt++;
        end
        if (cnt == n) @(negedge ref_clk);
        tx_valid = 1'b0;
        if (term_lf_sw) exp_q.push_back(9'h00d);
        if (term_lf_sw) exp_q.push_back(9'h10a);
    endtask

    task automatic drain();
        u_ibsu_ctrl_model.send(1'b1, 8'h40 | {3'b000, addr_sw}, 1'b0);
        chk("talk", 9'h001, {8'h00, talk});
        while (exp_q.size() > 0) begin
            u_ibsu_ctrl_model.recv($urandom % 8, d, e);
            chk("tx byte", exp_q.pop_front(), {e, d});
        end
        u_ibsu_ctrl_model.send(1'b1, 8'h5f, 1'b0);
    endtask

    initial begin
        void'($urandom(32'h0229_fae2));
        // one instrument, an address of its own
        power_up(5'($urandom % 31), 1'b0, 1'b0, 8'h00);
        u_ibsu_ctrl_model.send(1'b1, 8'h14, 1'b0);
        chk("dev_clear", 9'h001, 9'(n_clr));
        chk("srq kept", 9'h001, {8'h00, bus_o.srq_oe});
        listen_msg();
        chk("srq pending", 9'h001, {8'h00, bus_o.srq_oe});
        poll(8'h41);
        fill(40, 31, k);
        chk("fifo depth", 9'h020, 9'(k));
        drain();
        power_up(5'($urandom % 31), 1'b1, 1'b0, 8'h00);
        listen_msg();
        fill(2, 1, k);
        drain();
        code = 8'($urandom);
        power_up(5'($urandom % 31), 1'b0, 1'b1, code);
        poll(code);
        @(negedge ref_clk);
        ev_set = 1'b1;
        ev_code = 6'($urandom);
        @(negedge ref_clk);
        ev_set = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("srq event", 9'h001, {8'h00, bus_o.srq_oe});
        u_ibsu_ctrl_model.send(1'b1, 8'h14, 1'b0);
        repeat (3) @(negedge ref_clk);
        chk("srq cleared", 9'h000, {8'h00, bus_o.srq_oe});
        power_up(5'h1f, 1'b0, 1'b0, 8'h00);
        u_ibsu_ctrl_model.send(1'b1, 8'h3f, 1'b0);
        u_ibsu_ctrl_model.send(1'b1, 8'h5f, 1'b0);
        u_ibsu_ctrl_model.send(1'b0, 8'h55, 1'b1);
        chk("off bus", 9'h000, {6'h00, listen, talk, 1'b0});
        chk("off bus rx", 9'h000, 9'(rx_q.size()));
        final_report();
    end

    initial begin
        repeat (80000) @(posedge ref_clk);
        $display("Error watchdog expected finish seen hang");
        mismatches++;
        final_report();
    end
endmodule

bind ibsu_top ibsu_top_sva u_ibsu_top_sva (.ref_clk(ref_clk), .reset_n(reset_n),
    .addr_sw(addr_sw), .term_lf_sw(term_lf_sw), .st_start(st_start), .st_done(st_done),
    .st_fail(st_fail), .st_code(st_code), .init_req(init_req), .bus_i(bus_i),
    .bus_o(bus_o), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_word(rx_word), .ev_set(ev_set), .ev_code(ev_code),
    .dev_clear(dev_clear), .listen(listen), .talk(talk));
